/* File: design/tc_pkg.sv */
// Contract
// (R01) Counter clears, counts up or down per mode on timer tick; stopped when select zero.
// (R02) Processor reads and writes the count at any time, running or stopped.
// (R03) Processor write to the count beats a same-cycle hardware clear or count.
// (R04) Counting sequence follows waveform mode only; output mode bits never affect it.
// (R05) Counter compared with compare value always; flag set at tick after equality.
// (R06) Flag with enable requests interrupt; cleared by service or writing one.
// (R07) PWM modes buffer compare value, loaded at top; other modes write directly.
// (R08) Compare accesses reach the buffer when buffering, else the active register.
// (R09) Non-PWM force strobe acts like a match, without flag and without clearing.
// (R10) Any count write blocks compare matches on the next timer tick, even stopped.
// (R11) Software should not write count equal to compare, nor zero counting down.
// (R12) Waveform mode changes leave the compare output state unchanged.
// (R13) Output mode bits take effect at the first match after writing.
// (R14) Nonzero output mode drives pin from compare output state in all modes.
// (R15) Pin direction stays under the direction bit; output shows only when driven.
// (R16) Output mode zero leaves compare output state unchanged on a match.
// (R17) Output mode bits select PWM polarity, or set, clear, toggle in non-PWM.
// (R18) Counter unit flags maximum value and bottom value.
// (R19) Normal mode counts up only, wrapping from maximum to zero.
// (R20) Normal mode sets overflow flag as counter becomes zero; counting never clears it.
// (R21) Overflow flag clears on interrupt service and may request an interrupt.
// (R22) Mode two clears the counter when it equals the compare value.
// (R23) Mode three counts zero to maximum and restarts; overflow set at maximum.
// (R24) Mode one counts up then down; overflow set when reaching zero.
// (R25) Non-PWM output modes one, two, three toggle, clear, set on match.
// (R26) Force strobe reads zero and does nothing in PWM modes.
package tc_pkg;
    localparam logic [7:0] TC_MAX = 8'hff;
    localparam logic [7:0] TC_BOTTOM = 8'h00;
    localparam logic [7:0] TC_ONE = 8'h01;

    typedef enum logic [1:0] {
        TC_NORMAL = 2'h0,
        TC_PCPWM = 2'h1,
        TC_CTC = 2'h2,
        TC_FAST = 2'h3
    } tc_wgm_t;

    localparam logic [1:0] TC_COM_OFF = 2'h0;
    localparam logic [1:0] TC_COM_TOG = 2'h1;
    localparam logic [1:0] TC_COM_CLR = 2'h2;
    localparam logic [1:0] TC_COM_SET = 2'h3;

    localparam logic [2:0] TC_CS_STOP = 3'h0;
    localparam logic [2:0] TC_CS_SYS = 3'h1;

    localparam logic [7:0] TC_A_CTRL = 8'h00;
    localparam logic [7:0] TC_A_COUNT = 8'h04;
    localparam logic [7:0] TC_A_CMP = 8'h08;
    localparam logic [7:0] TC_A_IEN = 8'h0c;
    localparam logic [7:0] TC_A_FLAG = 8'h10;
    localparam logic [7:0] TC_A_PIN = 8'h14;

    localparam int TC_CTRL_FOC = 7;
    localparam int TC_IEN_CMP = 0;
    localparam int TC_IEN_OVF = 1;
    localparam int TC_FLAG_CMP = 0;
    localparam int TC_FLAG_OVF = 1;
    localparam int TC_PIN_VAL = 0;
    localparam int TC_PIN_DIR = 1;

    localparam logic [1:0] TC_RESP_OK = 2'h0;
    localparam logic [1:0] TC_RESP_ERR = 2'h2;

    function automatic logic tc_is_pwm(tc_wgm_t m);
        return (m == TC_PCPWM) || (m == TC_FAST);
    endfunction

    function automatic logic tc_hit(logic [7:0] a, logic [7:0] o);
        return a[7:2] == o[7:2];
    endfunction
endpackage

/* File: design/tc_cnt_if.sv */
`timescale 1ns/100ps
interface tc_cnt_if;
    import tc_pkg::*;
    logic tick;
    tc_wgm_t mode;
    logic [7:0] ocr;
    logic [7:0] cnt;
    logic down;
    logic atMax;
    logic atBottom;
    logic wrEn;
    logic [7:0] wrData;

    modport ctr(
        input tick, mode, ocr, wrEn, wrData,
        output cnt, down, atMax, atBottom
    );
    modport cmp(input tick, mode, ocr, cnt, down, atMax);
    modport ctl(
        output tick, mode, ocr, wrEn, wrData,
        input cnt, down, atMax, atBottom
    );
endinterface

/* File: design/tc_counter.sv */
`timescale 1ns/100ps
module tc_counter
    import tc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    tc_cnt_if.ctr cif
);
    typedef struct packed {
        logic [7:0] cnt;
        logic down;
    } tc_ctr_st_t;

    tc_ctr_st_t st_q;
    tc_ctr_st_t st_d;

    always_comb
    begin
        st_d = st_q;
        // (R03) write beats count
        if (cif.wrEn)
            st_d.cnt = cif.wrData;
        // (R01) tick driven sequence
        else if (cif.tick)
        begin
            // (R04) sequence from mode
            unique case (cif.mode)
                // (R19) up only, wraps to zero
                TC_NORMAL, TC_FAST:
                    st_d.cnt = st_q.cnt + TC_ONE;
                TC_CTC:
                    // (R22) clear on compare
                    st_d.cnt = (st_q.cnt == cif.ocr) ? TC_BOTTOM
                                                     : st_q.cnt + TC_ONE;
                TC_PCPWM:
                begin
                    // (R24) dual slope
                    if (!st_q.down && st_q.cnt == TC_MAX)
                    begin
                        st_d.down = 1'b1;
                        st_d.cnt = st_q.cnt - TC_ONE;
                    end
                    else if (st_q.down && st_q.cnt == TC_BOTTOM)
                    begin
                        st_d.down = 1'b0;
                        st_d.cnt = st_q.cnt + TC_ONE;
                    end
                    else if (st_q.down)
                        st_d.cnt = st_q.cnt - TC_ONE;
                    else
                        st_d.cnt = st_q.cnt + TC_ONE;
                end
            endcase
            if (cif.mode != TC_PCPWM)
                st_d.down = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign cif.cnt = st_q.cnt;
    assign cif.down = st_q.down;
    // (R18) max and bottom
    assign cif.atMax = st_q.cnt == TC_MAX;
    assign cif.atBottom = st_q.cnt == TC_BOTTOM;

    a_ctr_write_wins: assert property ( // (R03)
        @(posedge clk) disable iff (!rst_n)
        cif.wrEn |=> cif.cnt == $past(cif.wrData))
        else $error("count write did not win");

    a_ctr_idle_hold: assert property ( // (R01)
        @(posedge clk) disable iff (!rst_n)
        !cif.tick && !cif.wrEn |=> $stable(cif.cnt))
        else $error("count moved without tick");

    a_ctr_normal_up: assert property ( // (R19)
        @(posedge clk) disable iff (!rst_n)
        cif.tick && !cif.wrEn && cif.mode == TC_NORMAL
        |=> cif.cnt == $past(cif.cnt) + TC_ONE)
        else $error("normal mode did not count up");
endmodule

/* File: design/tc_compare.sv */
`timescale 1ns/100ps
module tc_compare
    import tc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    tc_cnt_if.cmp cif,
    input wire logic [1:0] com,
    input wire logic block,
    input wire logic forceHit,
    output logic match,
    output logic ocState
);
    typedef struct packed {
        logic oc;
    } tc_cmp_st_t;

    tc_cmp_st_t st_q;
    tc_cmp_st_t st_d;

    // (R25) non-PWM match action
    function automatic logic tc_act(logic [1:0] m, logic cur);
        unique case (m)
            TC_COM_TOG: return ~cur;
            TC_COM_CLR: return 1'b0;
            TC_COM_SET: return 1'b1;
            default: return cur;
        endcase
    endfunction

    // (R05) equality, suppressed after a count write
    assign match = cif.tick && (cif.cnt == cif.ocr) && !block;

    always_comb
    begin
        st_d = st_q;
        // (R09) forced match, non-PWM only
        if (forceHit && !tc_is_pwm(cif.mode))
            st_d.oc = tc_act(com, st_q.oc);
        else if (cif.tick)
        begin
            // (R17) action per mode and output bits
            unique case (cif.mode)
                TC_NORMAL, TC_CTC:
                    if (match)
                        st_d.oc = tc_act(com, st_q.oc);
                TC_FAST:
                    if (cif.atMax && com[1])
                        st_d.oc = ~com[0];
                    else if (match && com == TC_COM_TOG)
                        st_d.oc = ~st_q.oc;
                    else if (match && com[1])
                        st_d.oc = com[0];
                TC_PCPWM:
                    if (match && com[1])
                        st_d.oc = com[0] ^ cif.down;
            endcase
        end
    end

    // (R12) state kept across mode changes
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign ocState = st_q.oc;

    a_cmp_off_hold: assert property ( // (R16)
        @(posedge clk) disable iff (!rst_n)
        com == TC_COM_OFF |=> $stable(ocState))
        else $error("output changed with mode zero");

    a_cmp_force_set: assert property ( // (R09)
        @(posedge clk) disable iff (!rst_n)
        forceHit && !tc_is_pwm(cif.mode) && com == TC_COM_SET |=> ocState)
        else $error("force did not set output");
endmodule

/* File: design/tc_timer8.sv */
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
module tc_timer8
    import tc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] tickSrc,
    input wire logic compareIrqAck,
    input wire logic overflowIrqAck,
    output logic compareIrq,
    output logic overflowIrq,
    output logic pinOut,
    output logic pinOe_n
);
    typedef struct packed {
        tc_wgm_t wgm;
        logic [1:0] com;
        logic [2:0] cs;
        logic [7:0] ocr;
        logic [7:0] ocrBuf;
        logic cie;
        logic oie;
        logic ocf;
        logic tov;
        logic portVal;
        logic ddr;
        logic block;
        logic awHave;
        logic [7:0] awAddr;
        logic wHave;
        logic [7:0] wData;
        logic wLane0;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } tc_top_st_t;

    tc_top_st_t st_q;
    tc_top_st_t st_d;

    tc_cnt_if cif();

    logic tick;
    logic doWr;
    logic wb0;
    logic [7:0] wd;
    logic cntWr;
    logic forceHit;
    logic [1:0] cmpCom;
    logic match;
    logic ocState;
    logic ocfClr;
    logic tovSet;
    logic tovClr;
    logic pwm;
    logic topLoad;

    // ----------------------------------------
    // Register read mux
    // ----------------------------------------
    function automatic logic tc_known(logic [7:0] a);
        return tc_hit(a, TC_A_CTRL) || tc_hit(a, TC_A_COUNT)
            || tc_hit(a, TC_A_CMP) || tc_hit(a, TC_A_IEN)
            || tc_hit(a, TC_A_FLAG) || tc_hit(a, TC_A_PIN);
    endfunction

    function automatic logic [7:0] tc_read(logic [7:0] a, tc_top_st_t s,
                                           logic [7:0] c);
        logic [7:0] v;
        v = 8'h00;
        // (R26) force strobe reads zero
        if (tc_hit(a, TC_A_CTRL))
            v = {1'b0, s.cs, s.com, s.wgm};
        // (R02) count readable any time
        else if (tc_hit(a, TC_A_COUNT))
            v = c;
        // (R08) buffer when buffering
        else if (tc_hit(a, TC_A_CMP))
            v = tc_is_pwm(s.wgm) ? s.ocrBuf : s.ocr;
        else if (tc_hit(a, TC_A_IEN))
            v = {6'h00, s.oie, s.cie};
        else if (tc_hit(a, TC_A_FLAG))
            v = {6'h00, s.tov, s.ocf};
        else if (tc_hit(a, TC_A_PIN))
            v = {6'h00, s.ddr, s.portVal};
        return v;
    endfunction

    // ----------------------------------------
    // Timer tick and decode
    // ----------------------------------------
    // (R01) select zero stops the timer
    always_comb
    begin
        if (st_q.cs == TC_CS_STOP)
            tick = 1'b0;
        else if (st_q.cs == TC_CS_SYS)
            tick = 1'b1;
        else
            tick = tickSrc[st_q.cs];
    end

    assign pwm = tc_is_pwm(st_q.wgm);
    assign doWr = st_q.awHave && st_q.wHave && !st_q.bValid;
    assign wb0 = doWr && st_q.wLane0;
    assign wd = st_q.wData;
    // (R02) count written any time
    assign cntWr = wb0 && tc_hit(st_q.awAddr, TC_A_COUNT);
    // (R26) strobe ignored in PWM modes
    assign forceHit = wb0 && tc_hit(st_q.awAddr, TC_A_CTRL)
                   && wd[TC_CTRL_FOC] && !pwm;
    // (R13) forced match uses the bits written with it
    assign cmpCom = forceHit ? wd[3:2] : st_q.com;
    // (R06) serviced or written one
    assign ocfClr = compareIrqAck
                 || (wb0 && tc_hit(st_q.awAddr, TC_A_FLAG)
                     && wd[TC_FLAG_CMP]);
    // (R21) service clears overflow
    assign tovClr = overflowIrqAck
                 || (wb0 && tc_hit(st_q.awAddr, TC_A_FLAG)
                     && wd[TC_FLAG_OVF]);
    // (R07) top of count for reload
    assign topLoad = tick && pwm && cif.atMax;

    // ----------------------------------------
    // Overflow detection
    // ----------------------------------------
    always_comb
    begin
        tovSet = 1'b0;
        if (tick && !cntWr)
        begin
            unique case (st_q.wgm)
                // (R20) becomes zero from maximum
                TC_NORMAL, TC_CTC:
                    tovSet = cif.atMax;
                // (R23) at maximum, single slope
                TC_FAST:
                    tovSet = cif.atMax;
                // (R24) reaching zero on the way down
                TC_PCPWM:
                    tovSet = cif.down && cif.cnt == TC_ONE;
            endcase
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        st_d = st_q;
        if (s_axi_awvalid && !st_q.awHave)
        begin
            st_d.awHave = 1'b1;
            st_d.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_q.wHave)
        begin
            st_d.wHave = 1'b1;
            st_d.wData = s_axi_wdata[7:0];
            st_d.wLane0 = s_axi_wstrb[0];
        end
        if (st_q.bValid && s_axi_bready)
            st_d.bValid = 1'b0;
        if (doWr)
        begin
            st_d.awHave = 1'b0;
            st_d.wHave = 1'b0;
            st_d.bValid = 1'b1;
            st_d.bResp = tc_known(st_q.awAddr) ? TC_RESP_OK : TC_RESP_ERR;
        end
        if (st_q.rValid && s_axi_rready)
            st_d.rValid = 1'b0;
        if (s_axi_arvalid && !st_q.rValid)
        begin
            st_d.rValid = 1'b1;
            st_d.rData = {24'h000000, tc_read(s_axi_araddr, st_q, cif.cnt)};
            st_d.rResp = tc_known(s_axi_araddr) ? TC_RESP_OK : TC_RESP_ERR;
        end
        // (R13) output bits used at once
        if (wb0 && tc_hit(st_q.awAddr, TC_A_CTRL))
        begin
            st_d.wgm = tc_wgm_t'(wd[1:0]);
            st_d.com = wd[3:2];
            st_d.cs = wd[6:4];
        end
        if (wb0 && tc_hit(st_q.awAddr, TC_A_IEN))
        begin
            st_d.cie = wd[TC_IEN_CMP];
            st_d.oie = wd[TC_IEN_OVF];
        end
        if (wb0 && tc_hit(st_q.awAddr, TC_A_PIN))
        begin
            st_d.portVal = wd[TC_PIN_VAL];
            st_d.ddr = wd[TC_PIN_DIR];
        end
        // (R07) reload at top
        if (topLoad)
            st_d.ocr = st_q.ocrBuf;
        // (R08) buffer or direct
        if (wb0 && tc_hit(st_q.awAddr, TC_A_CMP))
        begin
            st_d.ocrBuf = wd;
            if (!pwm)
                st_d.ocr = wd;
        end
        // (R10) block the next tick's match
        if (cntWr)
            st_d.block = 1'b1;
        else if (tick)
            st_d.block = 1'b0;
        // (R05) set wins over clear
        st_d.ocf = match || (st_q.ocf && !ocfClr);
        st_d.tov = tovSet || (st_q.tov && !tovClr);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    // ----------------------------------------
    // Counter and compare units
    // ----------------------------------------
    assign cif.tick = tick;
    assign cif.mode = st_q.wgm;
    assign cif.ocr = st_q.ocr;
    // (R03) write overrides hardware update
    assign cif.wrEn = cntWr;
    assign cif.wrData = wd;

    tc_counter u_counter (
        .clk(clk),
        .rst_n(rst_n),
        .cif(cif.ctr)
    );

    tc_compare u_compare (
        .clk(clk),
        .rst_n(rst_n),
        .cif(cif.cmp),
        .com(cmpCom),
        .block(st_q.block),
        .forceHit(forceHit),
        .match(match),
        .ocState(ocState)
    );

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign s_axi_awready = !st_q.awHave;
    assign s_axi_wready = !st_q.wHave;
    assign s_axi_bvalid = st_q.bValid;
    assign s_axi_bresp = st_q.bResp;
    assign s_axi_arready = !st_q.rValid;
    assign s_axi_rvalid = st_q.rValid;
    assign s_axi_rdata = st_q.rData;
    assign s_axi_rresp = st_q.rResp;
    // (R06) flag gated by enable
    assign compareIrq = st_q.cie && st_q.ocf;
    assign overflowIrq = st_q.oie && st_q.tov;
    // (R14) override when output mode nonzero
    assign pinOut = (st_q.com != TC_COM_OFF) ? ocState : st_q.portVal;
    // (R15) direction bit alone enables the pin
    assign pinOe_n = !st_q.ddr;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_block_after_write: assert property ( // (R10)
        @(posedge clk) disable iff (!rst_n)
        cntWr |=> st_q.block && !match)
        else $error("match not blocked after count write");

    a_match_sets_flag: assert property ( // (R05)
        @(posedge clk) disable iff (!rst_n)
        match |=> st_q.ocf)
        else $error("match did not set flag");

    a_flag_clear: assert property ( // (R06)
        @(posedge clk) disable iff (!rst_n)
        st_q.ocf && ocfClr && !match |=> !st_q.ocf)
        else $error("flag not cleared");

    a_tov_normal_wrap: assert property ( // (R20)
        @(posedge clk) disable iff (!rst_n)
        tick && !cntWr && st_q.wgm == TC_NORMAL && cif.atMax
        |=> st_q.tov && cif.cnt == TC_BOTTOM)
        else $error("normal wrap did not set overflow");

    a_cmp_direct: assert property ( // (R07)
        @(posedge clk) disable iff (!rst_n)
        wb0 && tc_hit(st_q.awAddr, TC_A_CMP) && !pwm
        |=> st_q.ocr == $past(wd))
        else $error("direct compare write lost");

    a_irq_request: assert property ( // (R06)
        @(posedge clk) disable iff (!rst_n)
        st_q.cie && st_q.ocf |-> compareIrq)
        else $error("compare interrupt missing");

    a_pin_override: assert property ( // (R14)
        @(posedge clk) disable iff (!rst_n)
        st_q.com != TC_COM_OFF
        |-> pinOut == ocState && pinOe_n == !st_q.ddr)
        else $error("pin override wrong");

    a_force_noflag: assert property ( // (R09)
        @(posedge clk) disable iff (!rst_n)
        forceHit && !match && !st_q.ocf |=> !st_q.ocf)
        else $error("force set the flag");
endmodule

/* File: verification/tc_core_model.sv */
`timescale 1ns/100ps
module tc_core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tickReq,
    input wire logic svcEn,
    input wire logic compareIrq,
    input wire logic overflowIrq,
    output logic [7:0] tickSrc,
    output logic compareIrqAck,
    output logic overflowIrqAck
);
    logic [1:0] divQ;

    // Src 2 on demand, src 3 free divide by four
    assign tickSrc = {4'h0, divQ == 2'h3, tickReq, 2'b00};

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            divQ <= 2'h0;
            compareIrqAck <= 1'b0;
            overflowIrqAck <= 1'b0;
        end
        else
        begin
            divQ <= divQ + 2'h1;
            compareIrqAck <= svcEn && compareIrq && !compareIrqAck;
            overflowIrqAck <= svcEn && overflowIrq && !overflowIrqAck;
        end
    end
endmodule

/* File: verification/tc_timer8_tb.sv */
`timescale 1ns/100ps
`define CK(nm, e, s) \
    begin \
        testsRun++; \
        if ((s) !== (e)) \
        begin \
            errors++; \
            $display("[ERR] %s exp %h got %h", nm, e, s); \
        end \
    end
module tc_timer8_tb
    import tc_pkg::*;
    ;
    logic clk = 0, rstN = 0, tickReq = 0, svcEn = 0;
    logic [7:0] awAddr = 0, arAddr = 0;
    logic [31:0] wData = 0;
    logic awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
    logic awReady, wReady, bValid, arReady, rValid;
    logic [1:0] bResp, rResp;
    logic [31:0] rData;
    logic [7:0] tickSrc;
    logic cAck, oAck, cIrq, oIrq, pinOut, pinOeN;
    logic [1:0] st [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
    logic ex [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    int errors = 0, testsRun = 0;

    tc_timer8 i_dut (.clk(clk), .rst_n(rstN),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .tickSrc(tickSrc),
        .compareIrqAck(cAck), .overflowIrqAck(oAck),
        .compareIrq(cIrq), .overflowIrq(oIrq),
        .pinOut(pinOut), .pinOe_n(pinOeN));
    tc_core_model i_core (.clk(clk), .rst_n(rstN), .tickReq(tickReq),
        .svcEn(svcEn), .compareIrq(cIrq), .overflowIrq(oIrq),
        .tickSrc(tickSrc), .compareIrqAck(cAck),
        .overflowIrqAck(oAck));

    initial
    begin
        forever #2 clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", testsRun, errors);
        if (errors == 0 && testsRun > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
        input logic [1:0] er = TC_RESP_OK);
        int n = 0;
        logic aTk, wTk, bTk;
        logic [1:0] resp;
        awAddr <= a;
        wData <= {24'h0, d};
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        do
        begin
            // Handshakes judged mid-cycle, acted on at the edge
            @(negedge clk);
            aTk = awValid && awReady;
            wTk = wValid && wReady;
            bTk = bValid === 1'b1;
            resp = bResp;
            @(posedge clk);
            if (aTk) awValid <= 1'b0;
            if (wTk) wValid <= 1'b0;
            n++;
        end while (!bTk && n < 200);
        bReady <= 1'b0;
        @(posedge clk);
        `CK("bvalid", 1'b1, bTk);
        `CK("bresp", er, resp);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e,
        input logic [1:0] er = TC_RESP_OK);
        int n = 0;
        logic arTk, rTk;
        logic [1:0] resp;
        logic [31:0] dat;
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do
        begin
            @(negedge clk);
            arTk = arValid && arReady;
            rTk = rValid === 1'b1;
            resp = rResp;
            dat = rData;
            @(posedge clk);
            if (arTk) arValid <= 1'b0;
            n++;
        end while (!rTk && n < 200);
        rReady <= 1'b0;
        @(posedge clk);
        `CK("rvalid", 1'b1, rTk);
        `CK("rresp", er, resp);
        if (er == TC_RESP_OK) `CK("rdata", {24'h0, e}, dat);
    endtask

    task automatic tick();
        tickReq <= 1'b1;
        @(posedge clk);
        tickReq <= 1'b0;
        @(posedge clk);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        conclude();
    end

    initial
    begin
        repeat (4) @(posedge clk);
        rstN <= 1'b1;
        @(posedge clk);
        rd(TC_A_CTRL, 8'h00);
        `CK("oe", 1'b1, pinOeN);
        wr(TC_A_COUNT, 8'h10);
        tick();
        rd(TC_A_COUNT, 8'h10);
        wr(TC_A_CMP, 8'h80);
        wr(TC_A_COUNT, 8'hfe);
        wr(TC_A_CTRL, 8'h20);
        tick();
        rd(TC_A_COUNT, 8'hff);
        tick();
        rd(TC_A_COUNT, 8'h00);
        tick();
        rd(TC_A_FLAG, 8'h02);
        wr(TC_A_FLAG, 8'h02);
        rd(TC_A_FLAG, 8'h00);
        wr(TC_A_CMP, 8'h03);
        wr(TC_A_COUNT, 8'h03);
        tick();
        rd(TC_A_FLAG, 8'h00);
        wr(TC_A_COUNT, 8'h02);
        tick();
        tick();
        rd(TC_A_FLAG, 8'h01);
        wr(TC_A_IEN, 8'h01);
        `CK("cirq", 1'b1, cIrq);
        svcEn <= 1'b1;
        repeat (4) @(posedge clk);
        svcEn <= 1'b0;
        rd(TC_A_FLAG, 8'h00);
        wr(TC_A_CTRL, 8'h00);
        wr(TC_A_PIN, 8'h02);
        `CK("oe", 1'b0, pinOeN);
        `CK("pin", 1'b0, pinOut);
        for (int i = 0; i < 4; i++)
        begin
            wr(TC_A_CTRL, {1'b1, 3'h0, st[i], 2'h0});
            `CK("pin", ex[i], pinOut);
        end
        rd(TC_A_CTRL, 8'h0c);
        rd(TC_A_FLAG, 8'h00);
        wr(TC_A_CTRL, 8'h80);
        wr(TC_A_CTRL, 8'h08);
        `CK("pin", 1'b1, pinOut);
        wr(TC_A_CTRL, 8'h0a);
        `CK("pin", 1'b1, pinOut);
        wr(TC_A_CTRL, 8'h07);
        wr(TC_A_CTRL, 8'h87);
        `CK("pin", 1'b1, pinOut);
        rd(TC_A_CTRL, 8'h07);
        wr(TC_A_CMP, 8'h09);
        rd(TC_A_CMP, 8'h09);
        wr(TC_A_CTRL, 8'h23);
        wr(TC_A_COUNT, 8'h01);
        repeat (3) tick();
        rd(TC_A_FLAG, 8'h01);
        wr(TC_A_COUNT, 8'hff);
        tick();
        rd(TC_A_FLAG, 8'h03);
        wr(TC_A_IEN, 8'h02);
        `CK("oirq", 1'b1, oIrq);
        svcEn <= 1'b1;
        repeat (4) @(posedge clk);
        svcEn <= 1'b0;
        rd(TC_A_FLAG, 8'h01);
        wr(TC_A_CTRL, 8'h22);
        wr(TC_A_COUNT, 8'h08);
        tick();
        tick();
        rd(TC_A_COUNT, 8'h00);
        wr(TC_A_CTRL, 8'h21);
        wr(TC_A_COUNT, 8'hfe);
        tick();
        tick();
        rd(TC_A_COUNT, 8'hfe);
        wr(8'h20, 8'h00, TC_RESP_ERR);
        rd(8'h20, 8'h00, TC_RESP_ERR);
        conclude();
    end
endmodule
